// file: src/tat_pkg.sv
// Constants and types for the touch toggle auto-off timer
package tat_pkg;
	// Register byte offsets
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_RATIO = 5'h04;
	localparam logic [4:0] ADDR_STRAP = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_REMAIN = 5'h10;
	// Field positions
	localparam int CTRL_POL_LOW_BIT = 0;
	localparam int STAT_OUT_ON_BIT = 0;
	localparam int STAT_VALID_BIT = 1;
	localparam int STAT_X24_BIT = 2;
	localparam int STAT_INF_BIT = 3;
	localparam int STAT_STATE_LSB = 4;
	// Reset values
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [7:0] RATIO_RESET = 8'h3c;
	localparam logic [1:0] STRAP_RESET = 2'h0;
	// Delay select strap codes
	localparam logic [1:0] STRAP_VSS = 2'h0;
	localparam logic [1:0] STRAP_VDD = 2'h1;
	localparam logic [1:0] STRAP_OUT = 2'h2;
	localparam logic [1:0] STRAP_RC = 2'h3;
	// Timing
	localparam int CLK_HZ = 50000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int SETTLE_MS = 250;
	localparam int RECAL_MS = 200;
	localparam int SUSTAIN_MS = 65;
	localparam int CANCEL_MS = 250;
	localparam int LONG_MS = (SUSTAIN_MS + CANCEL_MS) / 2;
	localparam int UNIT_S = 15;
	localparam int UNIT_MS = UNIT_S * 1000;
	// Delay ratio window and presets, in units of UNIT_S
	localparam logic [7:0] RATIO_MIN = 8'h04;
	localparam logic [7:0] RATIO_MAX = 8'hf0;
	localparam logic [7:0] PRESET_15_UNITS = 8'(15 * 60 / UNIT_S);
	localparam logic [7:0] PRESET_60_UNITS = 8'(60 * 60 / UNIT_S);
	localparam logic [4:0] MULT_HI = 5'h18;
	typedef enum logic [3:0] {
		ST_SETTLE = 4'h1,
		ST_RECAL = 4'h2,
		ST_RUN = 4'h4,
		ST_OVR = 4'h8
	} tat_state_e;
endpackage

// file: src/tat_auto_off.sv
// Auto-off timer, override decoding and power-on sequencing
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module tat_auto_off #(
	parameter int CYC_PER_MS = tat_pkg::CYC_PER_MS,
	parameter int UNIT_MS = tat_pkg::UNIT_MS
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic multiplier_level,
	input wire logic touch_det,
	output logic out_pin,
	output logic out_valid,
	output logic burst_en
);
	tat_pkg::tat_state_e state_r;
	logic lvl_m_r, lvl_s_r;
	logic x24_r, x24_taken_r;
	logic pol_low_r;
	logic [7:0] ratio_r;
	logic [1:0] strap_r;
	logic [15:0] div_r;
	logic ms_tick_r;
	logic [8:0] phase_r;
	logic [13:0] unit_cnt_r;
	logic [12:0] remain_r;
	logic out_on_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic out_pin_r, valid_r, burst_r;
	logic inf;
	logic [7:0] base;
	logic [12:0] load;
	logic unit_evt, ovr_seen, ovr_long, lvl_back, touch_ok;

	// Level from the host crosses into this clock through two flops
	always_ff @(posedge sys_clk) begin
		lvl_m_r <= multiplier_level;
		lvl_s_r <= lvl_m_r;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_r <= 16'h0000;
			ms_tick_r <= 1'b0;
		end else if (div_r == 16'(CYC_PER_MS - 1)) begin
			div_r <= 16'h0000;
			ms_tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 16'h0001;
			ms_tick_r <= 1'b0;
		end
	end

	// Taken once, at the first millisecond tick after release so the synchroniser is full
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			x24_r <= 1'b0;
			x24_taken_r <= 1'b0;
		end else if (!x24_taken_r && ms_tick_r) begin
			x24_r <= lvl_s_r;
			x24_taken_r <= 1'b1;
		end
	end

	// Delay selection
	always_comb begin
		inf = 1'b0;
		base = tat_pkg::PRESET_60_UNITS;
		case (strap_r)
		tat_pkg::STRAP_VSS: begin
			inf = !pol_low_r;
			base = tat_pkg::PRESET_15_UNITS;
		end
		tat_pkg::STRAP_VDD: begin
			inf = pol_low_r;
			base = tat_pkg::PRESET_15_UNITS;
		end
		tat_pkg::STRAP_OUT: begin
			base = tat_pkg::PRESET_60_UNITS;
		end
		default: begin
			if (ratio_r < tat_pkg::RATIO_MIN) begin
				base = tat_pkg::PRESET_60_UNITS;
			end else if (ratio_r > tat_pkg::RATIO_MAX) begin
				inf = 1'b1;
			end else begin
				base = ratio_r;
			end
		end
		endcase
	end
	// Widen before the product so a long preset times 24 is not cut to 8 bits
	assign load = x24_r ? 13'(base) * 13'(tat_pkg::MULT_HI) : {5'h00, base};

	assign unit_evt = ms_tick_r && unit_cnt_r == 14'(UNIT_MS - 1);
	assign ovr_seen = ms_tick_r && lvl_s_r != x24_r;
	assign ovr_long = phase_r >= 9'(tat_pkg::LONG_MS);
	assign lvl_back = ms_tick_r && lvl_s_r == x24_r;
	assign touch_ok = state_r == tat_pkg::ST_RUN && touch_det;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_r <= tat_pkg::ST_SETTLE;
			phase_r <= 9'h000;
		end else begin
			case (state_r)
			tat_pkg::ST_SETTLE: begin
				if (ms_tick_r && phase_r == 9'(tat_pkg::SETTLE_MS - 1)) begin
					state_r <= tat_pkg::ST_RECAL;
					phase_r <= 9'h000;
				end else if (ms_tick_r) begin
					phase_r <= phase_r + 9'h001;
				end
			end
			tat_pkg::ST_RECAL: begin
				if (ms_tick_r && phase_r == 9'(tat_pkg::RECAL_MS - 1)) begin
					state_r <= tat_pkg::ST_RUN;
					phase_r <= 9'h000;
				end else if (ms_tick_r) begin
					phase_r <= phase_r + 9'h001;
				end
			end
			tat_pkg::ST_RUN: begin
				if (ovr_seen) begin
					state_r <= tat_pkg::ST_OVR;
					phase_r <= 9'h001;
				end
			end
			default: begin
				if (lvl_back) begin
					state_r <= tat_pkg::ST_RECAL;
					phase_r <= 9'h000;
				end else if (ms_tick_r && phase_r != 9'h1ff) begin
					phase_r <= phase_r + 9'h001;
				end
			end
			endcase
		end
	end

	// Toggle, auto-off countdown, sustain and cancel
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			out_on_r <= 1'b0;
			remain_r <= 13'h0000;
			unit_cnt_r <= 14'h0000;
		end else if (state_r == tat_pkg::ST_OVR && ovr_long) begin
			out_on_r <= 1'b0;
			remain_r <= 13'h0000;
			unit_cnt_r <= 14'h0000;
		end else if (state_r == tat_pkg::ST_OVR && lvl_back) begin
			if (out_on_r && !inf) begin
				remain_r <= load;
				unit_cnt_r <= 14'h0000;
			end
		end else if (touch_ok) begin
			out_on_r <= !out_on_r;
			remain_r <= (!out_on_r && !inf) ? load : 13'h0000;
			unit_cnt_r <= 14'h0000;
		end else if (state_r == tat_pkg::ST_RUN && out_on_r && !inf) begin
			if (unit_evt && remain_r <= 13'h0001) begin
				out_on_r <= 1'b0;
				remain_r <= 13'h0000;
				unit_cnt_r <= 14'h0000;
			end else if (unit_evt) begin
				remain_r <= remain_r - 13'h0001;
				unit_cnt_r <= 14'h0000;
			end else if (ms_tick_r) begin
				unit_cnt_r <= unit_cnt_r + 14'h0001;
			end
		end
	end

	// Pin stays at its inactive level while output is not yet valid
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			out_pin_r <= 1'b0;
			valid_r <= 1'b0;
			burst_r <= 1'b0;
		end else begin
			out_pin_r <= out_on_r ^ pol_low_r;
			valid_r <= state_r != tat_pkg::ST_SETTLE;
			burst_r <= state_r != tat_pkg::ST_OVR;
		end
	end

	// Avalon slave: one wait cycle, then answer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
			rdata_r <= 32'h00000000;
			if (avs_address == tat_pkg::ADDR_CTRL) begin
				rdata_r[tat_pkg::CTRL_POL_LOW_BIT] <= pol_low_r;
			end else if (avs_address == tat_pkg::ADDR_RATIO) begin
				rdata_r[7:0] <= ratio_r;
			end else if (avs_address == tat_pkg::ADDR_STRAP) begin
				rdata_r[1:0] <= strap_r;
			end else if (avs_address == tat_pkg::ADDR_STATUS) begin
				rdata_r[tat_pkg::STAT_OUT_ON_BIT] <= out_on_r;
				rdata_r[tat_pkg::STAT_VALID_BIT] <= valid_r;
				rdata_r[tat_pkg::STAT_X24_BIT] <= x24_r;
				rdata_r[tat_pkg::STAT_INF_BIT] <= inf;
				rdata_r[tat_pkg::STAT_STATE_LSB +: 4] <= state_r;
			end else if (avs_address == tat_pkg::ADDR_REMAIN) begin
				rdata_r[12:0] <= remain_r;
			end
		end else begin
			wait_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pol_low_r <= tat_pkg::CTRL_RESET;
			ratio_r <= tat_pkg::RATIO_RESET;
			strap_r <= tat_pkg::STRAP_RESET;
		end else if (avs_write && !wait_r) begin
			if (avs_address == tat_pkg::ADDR_CTRL) begin
				pol_low_r <= avs_writedata[tat_pkg::CTRL_POL_LOW_BIT];
			end else if (avs_address == tat_pkg::ADDR_RATIO) begin
				ratio_r <= avs_writedata[7:0];
			end else if (avs_address == tat_pkg::ADDR_STRAP) begin
				strap_r <= avs_writedata[1:0];
			end
		end
	end
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign out_pin = out_pin_r;
	assign out_valid = valid_r;
	assign burst_en = burst_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_settle_invalid;
		state_r == tat_pkg::ST_SETTLE |=> !valid_r;
	endproperty
	a_settle_invalid: assert property (p_settle_invalid) else $error("valid during settle");
	property p_recal_follows;
		state_r == tat_pkg::ST_SETTLE && ms_tick_r
			&& phase_r == 9'(tat_pkg::SETTLE_MS - 1)
			|=> state_r == tat_pkg::ST_RECAL ##1 !touch_ok;
	endproperty
	a_recal_follows: assert property (p_recal_follows) else $error("no recal after settle");
	property p_burst_hold;
		state_r == tat_pkg::ST_OVR |=> !burst_r;
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst during override");
	property p_cancel;
		state_r == tat_pkg::ST_OVR && ovr_long |=> !out_on_r ##1 !out_on_r;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel ignored");
	property p_return;
		state_r == tat_pkg::ST_OVR && lvl_back
			|=> state_r == tat_pkg::ST_RECAL && out_on_r == $past(out_on_r);
	endproperty
	a_return: assert property (p_return) else $error("no recal on return");
	property p_expire;
		state_r == tat_pkg::ST_RUN && out_on_r && !inf && unit_evt
			&& remain_r == 13'h0001 && !touch_ok
			|=> !out_on_r && remain_r == 13'h0000;
	endproperty
	a_expire: assert property (p_expire) else $error("delay did not expire");
	property p_sustain;
		state_r == tat_pkg::ST_OVR && lvl_back && !ovr_long && out_on_r && !inf
			|=> remain_r == $past(load);
	endproperty
	a_sustain: assert property (p_sustain) else $error("sustain not reloaded");
	property p_start;
		touch_ok && !out_on_r && !inf
			|=> out_on_r && remain_r == $past(load) && unit_cnt_r == 14'h0000;
	endproperty
	a_start: assert property (p_start) else $error("counter not started");
	property p_ovr_detect;
		state_r == tat_pkg::ST_RUN && ovr_seen |=> state_r == tat_pkg::ST_OVR;
	endproperty
	a_ovr_detect: assert property (p_ovr_detect) else $error("override missed");
endmodule

// file: bench/tat_host_model.sv
// Host model that pulses the multiplier level
`timescale 1ns/1ns
module tat_host_model #(
	parameter int CYC_PER_MS = 10
) (
	input wire logic sys_clk,
	input wire logic idle_level,
	input wire logic go,
	input wire logic [15:0] len_ms,
	output logic multiplier_level,
	output logic busy
);
	int cnt = 0;
	always_ff @(posedge sys_clk) begin
		if (go && !busy) begin
			cnt <= int'(len_ms) * CYC_PER_MS;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign busy = cnt > 0;
	// Inverse of the idle level only while a pulse runs
	assign multiplier_level = busy ? !idle_level : idle_level;
endmodule

// file: bench/test_touch_toggle_auto_off_timer.sv
// Self-checking bench for the auto-off timer
`timescale 1ns/1ns
module test_touch_toggle_auto_off_timer;
	localparam int CM = 10;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic multiplier_level;
	logic touch_det = 1'h0;
	logic out_pin;
	logic out_valid;
	logic burst_en;
	logic idle = 1'h0;
	logic go = 1'h0;
	logic [15:0] len_ms = 16'h0;
	logic busy;
	logic [31:0] q;
	int n_errors = 0;
	int comparisons = 0;
	// Polarity, strap, ratio, infinite flag, expected units
	logic [31:0] tbl [7] = '{32'h0303_00f0, 32'h03f1_1000, 32'h003c_1000,
		32'h013c_003c, 32'h103c_003c, 32'h113c_1000, 32'h123c_00f0};
	always #10 sys_clk = ~sys_clk;
	tat_auto_off #(.CYC_PER_MS(CM), .UNIT_MS(3)) DUT (.sys_clk(sys_clk),
		.rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.multiplier_level(multiplier_level), .touch_det(touch_det),
		.out_pin(out_pin), .out_valid(out_valid), .burst_en(burst_en));
	tat_host_model #(.CYC_PER_MS(CM)) host (.sys_clk(sys_clk),
		.idle_level(idle), .go(go), .len_ms(len_ms),
		.multiplier_level(multiplier_level), .busy(busy));
	task automatic close_out();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(string what, logic exp, logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
		int i;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'h0) break;
		end
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (i == 20) begin
			n_errors++;
			close_out();
		end
	endtask
	task automatic rd(logic [4:0] a);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic wr(logic [4:0] a, logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic ms(int n);
		repeat (n * CM) @(posedge sys_clk);
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		rst_b <= 1'h0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'h1;
	endtask
	task automatic tap();
		@(posedge sys_clk);
		touch_det <= 1'h1;
		@(posedge sys_clk);
		touch_det <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic pulse(int n);
		@(posedge sys_clk);
		len_ms <= 16'(n);
		go <= 1'h1;
		@(posedge sys_clk);
		go <= 1'h0;
	endtask
	// Status reads are a few cycles each, so the bound is generous
	task automatic poll(logic [3:0] st, int lim);
		int i;
		for (i = 0; i < lim * CM; i++) begin
			rd(tat_pkg::ADDR_STATUS);
			if (q[7:4] === st) break;
		end
		chk("state", {28'h0, st}, {28'h0, q[7:4]});
		if (i == lim * CM) close_out();
	endtask
	task automatic setup_rc(logic [7:0] ratio);
		wr(tat_pkg::ADDR_STRAP, 32'h3);
		wr(tat_pkg::ADDR_RATIO, {24'h0, ratio});
	endtask
	task automatic t_power();
		rd(tat_pkg::ADDR_CTRL);
		chk("ctrl", 32'h0, q);
		rd(tat_pkg::ADDR_RATIO);
		chk("ratio", 32'h3c, q);
		rd(tat_pkg::ADDR_STRAP);
		chk("strap", 32'h0, q);
		rd(5'h14);
		chk("unmapped", 32'h0, q);
		tap();
		ms(240);
		chk1("valid early", 1'h0, out_valid);
		ms(15);
		chk1("valid", 1'h1, out_valid);
		tap();
		ms(180);
		rd(tat_pkg::ADDR_STATUS);
		chk("recal", 32'h2, {28'h0, q[7:4]});
		chk1("touch ignored", 1'h0, q[0]);
		chk1("x1", 1'h0, q[2]);
		poll(4'h4, 40);
		chk1("bursts", 1'h1, burst_en);
		$display("test power done");
	endtask
	task automatic t_auto();
		setup_rc(8'h04);
		tap();
		rd(tat_pkg::ADDR_REMAIN);
		chk("remain", 32'h4, q);
		ms(9);
		chk1("still on", 1'h1, out_pin);
		ms(5);
		chk1("expired", 1'h0, out_pin);
		rd(tat_pkg::ADDR_REMAIN);
		chk("cleared", 32'h0, q);
		$display("test auto done");
	endtask
	task automatic t_presets();
		logic [31:0] e;
		for (int k = 0; k < 7; k++) begin
			e = tbl[k];
			wr(tat_pkg::ADDR_CTRL, {31'h0, e[28]});
			wr(tat_pkg::ADDR_STRAP, {30'h0, e[25:24]});
			wr(tat_pkg::ADDR_RATIO, {24'h0, e[23:16]});
			tap();
			chk1("pin on", !e[28], out_pin);
			rd(tat_pkg::ADDR_STATUS);
			chk1("infinite", e[12], q[3]);
			rd(tat_pkg::ADDR_REMAIN);
			if (!e[12]) begin
				chk("units", {24'h0, e[7:0]}, q);
			end
			tap();
			chk1("pin off", e[28], out_pin);
		end
		wr(tat_pkg::ADDR_CTRL, 32'h0);
		$display("test presets done");
	endtask
	task automatic t_sustain();
		setup_rc(8'h64);
		tap();
		ms(60);
		pulse(65);
		ms(3);
		chk1("bursts held", 1'h0, burst_en);
		poll(4'h2, 80);
		chk1("on kept", 1'h1, q[0]);
		rd(tat_pkg::ADDR_REMAIN);
		chk1("reload", 1'h1, q >= 32'h63);
		poll(4'h4, 220);
		chk1("bursts", 1'h1, burst_en);
		$display("test sustain done");
	endtask
	task automatic t_cancel();
		pulse(250);
		ms(200);
		rd(tat_pkg::ADDR_STATUS);
		chk1("forced off", 1'h0, q[0]);
		chk1("bursts held", 1'h0, burst_en);
		tap();
		rd(tat_pkg::ADDR_STATUS);
		chk1("touch blocked", 1'h0, q[0]);
		poll(4'h2, 80);
		poll(4'h4, 220);
		chk1("stays off", 1'h0, out_pin);
		$display("test cancel done");
	endtask
	task automatic t_x24();
		idle <= 1'h1;
		do_reset();
		poll(4'h4, 500);
		chk1("x24", 1'h1, q[2]);
		setup_rc(8'h04);
		tap();
		rd(tat_pkg::ADDR_REMAIN);
		chk("remain x24", 32'h60, q);
		tap();
		wr(tat_pkg::ADDR_STRAP, 32'h2);
		tap();
		rd(tat_pkg::ADDR_REMAIN);
		chk("remain 60 x24", 32'h1680, q);
		$display("test x24 done");
	endtask
	initial begin
		do_reset();
		t_power();
		t_auto();
		t_presets();
		t_sustain();
		t_cancel();
		t_x24();
		close_out();
	end
endmodule
